// file: hdl/msc_pkg.sv
package msc_pkg;

  localparam int NUM_VPA = 3;
  localparam int FLAG_W  = 32;

  // bit positions in the completion flags word
  localparam int FLAG_NONHARM_LSB = 0;
  localparam int FLAG_MOTOR       = 3;
  localparam int FLAG_HARM_LSB    = 8;
  localparam int FLAG_SPECTRUM    = 16;

  // values after reset
  localparam logic [FLAG_W-1:0] FLAGS_RST = 32'h0000_0000;
  localparam logic              HOLD_RST  = 1'h0;

  // largest accepted parameter per set or run command
  localparam logic [2:0] HOLD_MAX  = 3'h1;
  localparam logic [2:0] ACCUMULATION_STATE_QUERY_MAX = 3'h1;
  localparam logic [2:0] SCOPE_MAX = 3'h2;
  localparam logic [2:0] STBY_MAX  = 3'h1;

  // integration query code while frozen by hold
  localparam logic [1:0] ACCUMULATION_STATE_QUERY_HELD_CODE = 2'h2;

  typedef enum logic [3:0] {
    CMD_HOLD_SET   = 4'h0,
    CMD_HOLD_Q     = 4'h1,
    CMD_ACCUM_RUN  = 4'h2,
    CMD_ACCUM_Q    = 4'h3,
    CMD_FLAGS_Q    = 4'h4,
    CMD_SCOPE_SET  = 4'h5,
    CMD_SCOPE_Q    = 4'h6,
    CMD_STBY_RUN   = 4'h7,
    CMD_STBY_Q     = 4'h8,
    CMD_CFG_COMMIT = 4'h9
  } msc_cmd_code_t;

  // codes equal the values returned by the queries
  typedef enum logic [1:0] {
    INT_STOP = 2'h0,
    INT_WAIT = 2'h1,
    INT_RUN  = 2'h3
  } msc_accumulation_state_query_t;

  typedef enum logic [2:0] {
    SCP_STOP_EMPTY = 3'h0,
    SCP_STOP_DATA  = 3'h1,
    SCP_SINGLE     = 3'h2,
    SCP_CONT_EMPTY = 3'h3,
    SCP_CONT_DATA  = 3'h4
  } msc_scope_t;

  typedef enum logic [2:0] {
    STB_NEVER     = 3'h0,
    STB_OP_STOP   = 3'h1,
    STB_DONE      = 3'h2,
    STB_WAIT_TRIG = 3'h3,
    STB_MIN_RUN   = 3'h4,
    STB_MIN_EXT   = 3'h5,
    STB_COLLECT   = 3'h6
  } msc_stby_t;

  typedef struct packed {
    msc_cmd_code_t code;
    logic [1:0]    analyzer;  // analyzer selector field, 1..3
    logic [2:0]    param;
  } msc_cmd_t;

  typedef struct packed {
    logic [FLAG_W-1:0] data;
    logic              error;
  } msc_rsp_t;

  typedef struct packed {
    logic [NUM_VPA-1:0] nonHarmDone;
    logic               motorDone;
    logic [NUM_VPA-1:0] harmDone;
    logic               spectrumDone;
  } msc_evt_t;

endpackage

// file: hdl/msc_flags.sv
`timescale 1ns/100ps
`default_nettype none
module msc_flags #(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] setBits,
  input  wire logic             clrStb,
  output var  logic [WIDTH-1:0] flags_r
);
  import msc_pkg::*;

  logic [WIDTH-1:0] flags_nxt;

  // set wins over clear, so an event landing on the read is kept
  always_comb begin
    flags_nxt = (flags_r & ~{WIDTH{clrStb}}) | setBits;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_r <= WIDTH'(FLAGS_RST);
    end else begin
      flags_r <= flags_nxt;
    end
  end
endmodule
`default_nettype wire

// file: hdl/msc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module msc_ctrl (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic                       cmdValid,
  input  wire msc_pkg::msc_cmd_t          cmd,
  output logic                            rspValid,
  output msc_pkg::msc_rsp_t               rsp,
  input  wire logic [msc_pkg::NUM_VPA-1:0] analyzerAvail,
  input  wire msc_pkg::msc_evt_t          evt,
  input  wire logic                       integDelayUsed,
  input  wire logic                       integDelayDone,
  input  wire logic                       scopeCaptured,
  input  wire logic [msc_pkg::NUM_VPA-1:0] stbyStartDetect,
  input  wire logic [msc_pkg::NUM_VPA-1:0] stbyTriggered,
  input  wire logic [msc_pkg::NUM_VPA-1:0] stbyMinElapsed,
  input  wire logic [msc_pkg::NUM_VPA-1:0] stbyFinished,
  output logic                            holdActive,
  output logic                            integUpdating,
  output logic                            integClear,
  output logic                            integDelayStart,
  output logic                            scopeRun,
  output logic                            scopeContinuous,
  output logic                            scopeClear,
  output logic [msc_pkg::NUM_VPA-1:0]      stbyRunning,
  output logic [msc_pkg::NUM_VPA-1:0]      stbyClear
);
  import msc_pkg::*;

  logic                hold_r,          hold_nxt;
  msc_accumulation_state_query_t          accumulation_state_query_r,         accumulation_state_query_nxt;
  msc_scope_t          scope_r,         scope_nxt;
  msc_stby_t           stby_r [NUM_VPA];
  msc_stby_t           stby_nxt [NUM_VPA];
  logic                rspValid_r,      rspValid_nxt;
  msc_rsp_t            rsp_r,           rsp_nxt;
  logic                integClear_r,    integClear_nxt;
  logic                integDly_r,      integDly_nxt;
  logic                scopeClear_r,    scopeClear_nxt;
  logic [NUM_VPA-1:0]  stbyClear_r,     stbyClear_nxt;
  logic                flagsClr;
  logic [FLAG_W-1:0]   flagSet;
  logic [FLAG_W-1:0]   flagWord;
  logic [1:0]          vIdx;

  // selector 0 and unfitted analyzers both count as unavailable
  function automatic logic analyzerOk(input logic [1:0] sel,
                                      input logic [NUM_VPA-1:0] avail);
    logic ok;
    ok = 1'b0;
    if (sel != 2'h0 && 32'(sel) <= NUM_VPA) begin
      ok = avail[sel - 2'h1];
    end
    return ok;
  endfunction

  function automatic logic stbyHasData(input msc_stby_t s);
    return (s == STB_MIN_RUN) || (s == STB_MIN_EXT) || (s == STB_COLLECT);
  endfunction

  always_comb begin
    flagSet = '0;
    flagSet[FLAG_NONHARM_LSB +: NUM_VPA] = evt.nonHarmDone;
    flagSet[FLAG_MOTOR]                  = evt.motorDone;
    flagSet[FLAG_HARM_LSB +: NUM_VPA]    = evt.harmDone;
    flagSet[FLAG_SPECTRUM]               = evt.spectrumDone;
  end

  msc_flags #(
    .WIDTH   (FLAG_W)
  ) u_flags (
    .mclk    (mclk),
    .rst     (rst),
    .setBits (flagSet),
    .clrStb  (flagsClr),
    .flags_r (flagWord)
  );

  always_comb begin
    hold_nxt       = hold_r;
    accumulation_state_query_nxt      = accumulation_state_query_r;
    scope_nxt      = scope_r;
    stby_nxt       = stby_r;
    rspValid_nxt   = 1'b0;
    rsp_nxt        = '0;
    integClear_nxt = 1'b0;
    integDly_nxt   = 1'b0;
    scopeClear_nxt = 1'b0;
    stbyClear_nxt  = '0;
    flagsClr       = 1'b0;
    vIdx           = cmd.analyzer - 2'h1;

    // engine progress first; a command in the same cycle overrides it
    if (accumulation_state_query_r == INT_WAIT && integDelayDone) begin
      accumulation_state_query_nxt = INT_RUN;
    end
    if (scopeCaptured) begin
      if (scope_r == SCP_SINGLE) begin
        scope_nxt = SCP_STOP_DATA;
      end else if (scope_r == SCP_CONT_EMPTY) begin
        scope_nxt = SCP_CONT_DATA;
      end
    end
    for (int i = 0; i < NUM_VPA; i++) begin
      if (stby_r[i] == STB_WAIT_TRIG && stbyTriggered[i]) begin
        stby_nxt[i] = STB_COLLECT;
      end else if (stby_r[i] == STB_MIN_RUN && stbyMinElapsed[i]) begin
        stby_nxt[i] = STB_MIN_EXT;
      end else if ((stby_r[i] == STB_MIN_EXT || stby_r[i] == STB_COLLECT) && stbyFinished[i]) begin
        stby_nxt[i] = STB_DONE;
      end
    end

    if (cmdValid) begin
      rspValid_nxt = 1'b1;
      unique case (cmd.code)
        CMD_HOLD_SET: begin
          if (cmd.param > HOLD_MAX) begin
            rsp_nxt.error = 1'b1;
          end else begin
            hold_nxt = cmd.param[0];
          end
        end
        CMD_HOLD_Q: begin
          rsp_nxt.data = FLAG_W'(hold_r);
        end
        CMD_ACCUM_RUN: begin
          if (cmd.param > ACCUMULATION_STATE_QUERY_MAX) begin
            rsp_nxt.error = 1'b1;
          end else if (cmd.param[0]) begin
            integClear_nxt = 1'b1;
            integDly_nxt   = integDelayUsed;
            accumulation_state_query_nxt      = integDelayUsed ? INT_WAIT : INT_RUN;
          end else begin
            accumulation_state_query_nxt = INT_STOP;
          end
        end
        CMD_ACCUM_Q: begin
          if (hold_r && accumulation_state_query_r != INT_STOP) begin
            rsp_nxt.data = FLAG_W'(ACCUMULATION_STATE_QUERY_HELD_CODE);
          end else begin
            rsp_nxt.data = FLAG_W'(accumulation_state_query_r);
          end
        end
        CMD_FLAGS_Q: begin
          rsp_nxt.data = flagWord;
          flagsClr     = 1'b1;
        end
        CMD_SCOPE_SET: begin
          if (cmd.param > SCOPE_MAX) begin
            rsp_nxt.error = 1'b1;
          end else if (cmd.param == 3'h0) begin
            if (scope_r == SCP_CONT_DATA) begin
              scope_nxt = SCP_STOP_DATA;
            end else if (scope_r != SCP_STOP_DATA) begin
              scope_nxt = SCP_STOP_EMPTY;
            end
          end else begin
            scopeClear_nxt = 1'b1;
            scope_nxt = (cmd.param == 3'h1) ? SCP_SINGLE : SCP_CONT_EMPTY;
          end
        end
        CMD_SCOPE_Q: begin
          rsp_nxt.data = FLAG_W'(scope_r);
        end
        CMD_STBY_RUN: begin
          if (!analyzerOk(cmd.analyzer, analyzerAvail)) begin
            rsp_nxt.error = 1'b1;
          end else if (cmd.param > STBY_MAX) begin
            rsp_nxt.error = 1'b1;
          end else if (cmd.param[0]) begin
            stbyClear_nxt[vIdx] = 1'b1;
            stby_nxt[vIdx] = stbyStartDetect[vIdx] ? STB_WAIT_TRIG : STB_MIN_RUN;
          end else if (stbyHasData(stby_r[vIdx])) begin
            stby_nxt[vIdx] = STB_OP_STOP;
          end else if (stby_r[vIdx] == STB_WAIT_TRIG) begin
            // stopped before any data: nothing to report
            stby_nxt[vIdx] = STB_NEVER;
          end
        end
        CMD_STBY_Q: begin
          if (!analyzerOk(cmd.analyzer, analyzerAvail)) begin
            rsp_nxt.error = 1'b1;
          end else begin
            rsp_nxt.data = FLAG_W'(stby_r[vIdx]);
          end
        end
        CMD_CFG_COMMIT: begin
          flagsClr = 1'b1;
        end
        default: begin
          rsp_nxt.error = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_r       <= HOLD_RST;
      accumulation_state_query_r      <= INT_STOP;
      scope_r      <= SCP_STOP_EMPTY;
      stby_r       <= '{default: STB_NEVER};
      rspValid_r   <= 1'b0;
      rsp_r        <= '0;
      integClear_r <= 1'b0;
      integDly_r   <= 1'b0;
      scopeClear_r <= 1'b0;
      stbyClear_r  <= '0;
    end else begin
      hold_r       <= hold_nxt;
      accumulation_state_query_r      <= accumulation_state_query_nxt;
      scope_r      <= scope_nxt;
      stby_r       <= stby_nxt;
      rspValid_r   <= rspValid_nxt;
      rsp_r        <= rsp_nxt;
      integClear_r <= integClear_nxt;
      integDly_r   <= integDly_nxt;
      scopeClear_r <= scopeClear_nxt;
      stbyClear_r  <= stbyClear_nxt;
    end
  end

  // hold freezes accumulation without losing its run state
  assign rspValid        = rspValid_r;
  assign rsp             = rsp_r;
  assign holdActive      = hold_r;
  assign integUpdating   = (accumulation_state_query_r == INT_RUN) && !hold_r;
  assign integClear      = integClear_r;
  assign integDelayStart = integDly_r;
  assign scopeRun        = (scope_r == SCP_SINGLE) || (scope_r == SCP_CONT_EMPTY)
                           || (scope_r == SCP_CONT_DATA);
  assign scopeContinuous = (scope_r == SCP_CONT_EMPTY) || (scope_r == SCP_CONT_DATA);
  assign scopeClear      = scopeClear_r;
  assign stbyClear       = stbyClear_r;

  generate
    for (genvar g = 0; g < NUM_VPA; g++) begin : g_stby
      assign stbyRunning[g] = (stby_r[g] == STB_WAIT_TRIG) || stbyHasData(stby_r[g]);
    end
  endgenerate
endmodule
`default_nettype wire

// file: verif/msc_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
module msc_ctrl_props (
  input wire logic                        mclk,
  input wire logic                        rst,
  input wire logic                        cmdValid,
  input wire msc_pkg::msc_cmd_t           cmd,
  input wire logic                        rspValid,
  input wire msc_pkg::msc_rsp_t           rsp,
  input wire logic [msc_pkg::NUM_VPA-1:0] analyzerAvail,
  input wire msc_pkg::msc_evt_t           evt,
  input wire logic                        integDelayUsed,
  input wire logic                        holdActive,
  input wire logic                        integUpdating,
  input wire logic                        integClear,
  input wire logic                        integDelayStart,
  input wire logic                        scopeRun,
  input wire logic                        scopeContinuous,
  input wire logic                        scopeClear,
  input wire logic [msc_pkg::NUM_VPA-1:0] stbyRunning,
  input wire logic [msc_pkg::NUM_VPA-1:0] stbyClear
);
  import msc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic fq;
  logic cm;
  assign fq = cmdValid && cmd.code == CMD_FLAGS_Q;
  assign cm = cmdValid && cmd.code == CMD_CFG_COMMIT;
  hold_set_a: assert property (cmdValid && cmd.code == CMD_HOLD_SET
    && cmd.param <= HOLD_MAX |=> holdActive == $past(cmd.param[0]) && !rsp.error)
    else $error("hold set not applied");
  hold_keep_a: assert property (cmdValid && cmd.code == CMD_HOLD_SET
    && cmd.param > HOLD_MAX |=> rsp.error && $stable(holdActive))
    else $error("bad hold value accepted");
  hold_query_a: assert property (cmdValid && cmd.code == CMD_HOLD_Q
    |=> rspValid && rsp.data == {31'h0, $past(holdActive)}) else $error("hold query wrong");
  accum_start_a: assert property (cmdValid && cmd.code == CMD_ACCUM_RUN
    && cmd.param == 3'h1 |=> integClear) else $error("no clear on accumulation start");
  accum_dly_a: assert property (cmdValid && cmd.code == CMD_ACCUM_RUN
    && cmd.param == 3'h1 |=> integDelayStart == $past(integDelayUsed))
    else $error("start delay not begun as configured");
  accum_stop_a: assert property (cmdValid && cmd.code == CMD_ACCUM_RUN
    && cmd.param == 3'h0 |=> !integUpdating) else $error("accumulation still updating");
  accum_held_a: assert property (holdActive |-> !integUpdating)
    else $error("accumulation updating while held");
  accum_query_a: assert property (cmdValid && cmd.code == CMD_ACCUM_Q && holdActive
    |=> rsp.data inside {32'h0, 32'h2}) else $error("held accumulation query wrong");
  accum_run_a: assert property (cmdValid && cmd.code == CMD_ACCUM_Q
    ##1 rsp.data == 32'h3 |-> integUpdating) else $error("running accumulation not updating");
  flags_clear_a: assert property ((fq && evt == '0) ##1 (evt == '0 && !fq) ##1 fq
    |=> rsp.data == '0) else $error("flags not cleared by read");
  flags_spec_a: assert property ((evt.spectrumDone && !fq && !cm) ##1 (!fq && !cm) ##1 fq
    |=> rsp.data[FLAG_SPECTRUM]) else $error("spectrum bit missing");
  commit_clear_a: assert property ((cm && evt == '0) ##1 (evt == '0 && !fq) ##1 fq
    |=> rsp.data == '0) else $error("flags not cleared by commit");
  scope_clear_a: assert property (cmdValid && cmd.code == CMD_SCOPE_SET
    && cmd.param inside {3'h1, 3'h2} |=> scopeClear) else $error("capture start kept old data");
  scope_mode_a: assert property (cmdValid && cmd.code == CMD_SCOPE_SET
    && cmd.param == 3'h2 |=> scopeRun && scopeContinuous)
    else $error("continuous capture not started");
  scope_stop_a: assert property (cmdValid && cmd.code == CMD_SCOPE_SET
    && cmd.param == 3'h0 |=> !scopeRun && !scopeContinuous)
    else $error("capture not stopped");
  stby_sel_a: assert property (cmdValid && cmd.code inside {CMD_STBY_RUN, CMD_STBY_Q}
    && cmd.analyzer == 2'h0 |=> rsp.error) else $error("selector zero accepted");
  stby_start_a: assert property (cmdValid && cmd.code == CMD_STBY_RUN
    && cmd.param == 3'h1 && cmd.analyzer == 2'h1 && analyzerAvail[0]
    |=> stbyClear[0] && stbyRunning[0]) else $error("standby run not started");
  stby_stop_a: assert property (cmdValid && cmd.code == CMD_STBY_RUN
    && cmd.param == 3'h0 && cmd.analyzer == 2'h2 && analyzerAvail[1]
    |=> !stbyRunning[1]) else $error("standby run not stopped");
  resp_timing_a: assert property (rspValid == $past(cmdValid))
    else $error("response not one cycle after command");
  resp_idle_a: assert property (!rspValid |-> rsp == '0)
    else $error("response word not idle");
  cover property (cmdValid && cmd.code == CMD_ACCUM_Q ##1 rsp.data == 32'h2);
  cover property (fq ##1 rsp.data == 32'h0001070f);
  cover property (cmdValid && cmd.code == CMD_STBY_Q ##1 rsp.data == 32'h6);
endmodule
bind msc_ctrl msc_ctrl_props chk_u (.mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmd(cmd),
  .rspValid(rspValid), .rsp(rsp), .analyzerAvail(analyzerAvail), .evt(evt),
  .integDelayUsed(integDelayUsed), .holdActive(holdActive), .integUpdating(integUpdating),
  .integClear(integClear), .integDelayStart(integDelayStart), .scopeRun(scopeRun),
  .scopeContinuous(scopeContinuous), .scopeClear(scopeClear), .stbyRunning(stbyRunning),
  .stbyClear(stbyClear));
`default_nettype wire

// file: verif/msc_host.sv
`timescale 1ns/100ps
`default_nettype none
module msc_host (
  input  wire logic              mclk,
  input  wire logic              rspValid,
  input  wire msc_pkg::msc_rsp_t rsp,
  output var  logic              cmdValid,
  output var  msc_pkg::msc_cmd_t cmd
);
  import msc_pkg::*;
  initial begin
    cmdValid = 1'b0;
    cmd = '0;
  end
  // one command per call; fields inverted once released so nothing stale is read
  task automatic send(input msc_cmd_code_t c, input logic [1:0] a, input logic [2:0] p,
                      output msc_rsp_t r);
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmd <= '{code: c, analyzer: a, param: p};
    @(posedge mclk);
    cmdValid <= 1'b0;
    cmd <= ~cmd;
    #1;
    r = (rspValid === 1'b1) ? rsp : 'x;
  endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import msc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cmdValid;
  msc_cmd_t cmd;
  logic rspValid;
  msc_rsp_t rsp;
  logic [2:0] analyzerAvail = 3'h3;
  logic integDelayUsed = 1'b1;
  logic [2:0] stbyStartDetect = 3'h1;
  logic [18:0] pv = '0;
  msc_evt_t evt;
  logic integDelayDone;
  logic scopeCaptured;
  logic [2:0] stbyTriggered;
  logic [2:0] stbyMinElapsed;
  logic [2:0] stbyFinished;
  int fail_count = 0;
  int n_checks = 0;
  // all engine pulses share one vector so a single task drives any of them
  assign {evt, integDelayDone, scopeCaptured, stbyTriggered, stbyMinElapsed, stbyFinished} = pv;
  initial begin
    forever #25 mclk = ~mclk;
  end
  msc_host host_u (.mclk(mclk), .rspValid(rspValid), .rsp(rsp), .cmdValid(cmdValid), .cmd(cmd));
  msc_ctrl dut_u (.mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmd(cmd), .rspValid(rspValid),
    .rsp(rsp), .analyzerAvail(analyzerAvail), .evt(evt), .integDelayUsed(integDelayUsed),
    .integDelayDone(integDelayDone), .scopeCaptured(scopeCaptured),
    .stbyStartDetect(stbyStartDetect), .stbyTriggered(stbyTriggered),
    .stbyMinElapsed(stbyMinElapsed), .stbyFinished(stbyFinished), .holdActive(),
    .integUpdating(), .integClear(), .integDelayStart(), .scopeRun(), .scopeContinuous(),
    .scopeClear(), .stbyRunning(), .stbyClear());
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic q(input msc_cmd_code_t c, input logic [1:0] a, input logic [2:0] p,
                   input logic [31:0] d, input logic e);
    msc_rsp_t r;
    host_u.send(c, a, p, r);
    chk(r, {d, e});
  endtask
  task automatic pulse(input logic [18:0] v);
    @(posedge mclk) pv <= v;
    @(posedge mclk) pv <= '0;
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    q(CMD_HOLD_Q, 2'h0, 3'h0, 32'h0, 1'b0);
    q(CMD_HOLD_SET, 2'h0, 3'h1, 32'h0, 1'b0);
    q(CMD_HOLD_SET, 2'h0, 3'h3, 32'h0, 1'b1);
    q(CMD_HOLD_Q, 2'h0, 3'h0, 32'h1, 1'b0);
    q(CMD_ACCUM_RUN, 2'h0, 3'h1, 32'h0, 1'b0);
    q(CMD_ACCUM_Q, 2'h0, 3'h0, 32'h2, 1'b0);
    q(CMD_HOLD_SET, 2'h0, 3'h0, 32'h0, 1'b0);
    q(CMD_ACCUM_Q, 2'h0, 3'h0, 32'h1, 1'b0);
    pulse(19'h400);
    q(CMD_ACCUM_Q, 2'h0, 3'h0, 32'h3, 1'b0);
    q(CMD_ACCUM_RUN, 2'h0, 3'h2, 32'h0, 1'b1);
    q(CMD_ACCUM_RUN, 2'h0, 3'h0, 32'h0, 1'b0);
    q(CMD_ACCUM_Q, 2'h0, 3'h0, 32'h0, 1'b0);
    pulse(19'h7f800);
    q(CMD_FLAGS_Q, 2'h0, 3'h0, 32'h0001070f, 1'b0);
    q(CMD_FLAGS_Q, 2'h0, 3'h0, 32'h0, 1'b0);
    pulse(19'h10000);
    pulse(19'h4000);
    q(CMD_FLAGS_Q, 2'h0, 3'h0, 32'h401, 1'b0);
    pulse(19'h7f800);
    q(CMD_CFG_COMMIT, 2'h0, 3'h0, 32'h0, 1'b0);
    q(CMD_FLAGS_Q, 2'h0, 3'h0, 32'h0, 1'b0);
    q(CMD_SCOPE_SET, 2'h0, 3'h1, 32'h0, 1'b0);
    q(CMD_SCOPE_Q, 2'h0, 3'h0, 32'h2, 1'b0);
    pulse(19'h200);
    q(CMD_SCOPE_Q, 2'h0, 3'h0, 32'h1, 1'b0);
    q(CMD_SCOPE_SET, 2'h0, 3'h2, 32'h0, 1'b0);
    q(CMD_SCOPE_Q, 2'h0, 3'h0, 32'h3, 1'b0);
    pulse(19'h200);
    q(CMD_SCOPE_Q, 2'h0, 3'h0, 32'h4, 1'b0);
    q(CMD_SCOPE_SET, 2'h0, 3'h3, 32'h0, 1'b1);
    q(CMD_SCOPE_SET, 2'h0, 3'h0, 32'h0, 1'b0);
    q(CMD_SCOPE_Q, 2'h0, 3'h0, 32'h1, 1'b0);
    q(CMD_STBY_RUN, 2'h3, 3'h1, 32'h0, 1'b1);
    q(CMD_STBY_RUN, 2'h0, 3'h1, 32'h0, 1'b1);
    q(CMD_STBY_Q, 2'h1, 3'h0, 32'h0, 1'b0);
    q(CMD_STBY_RUN, 2'h1, 3'h1, 32'h0, 1'b0);
    q(CMD_STBY_Q, 2'h1, 3'h0, 32'h3, 1'b0);
    pulse(19'h40);
    q(CMD_STBY_Q, 2'h1, 3'h0, 32'h6, 1'b0);
    pulse(19'h1);
    q(CMD_STBY_Q, 2'h1, 3'h0, 32'h2, 1'b0);
    q(CMD_STBY_RUN, 2'h2, 3'h1, 32'h0, 1'b0);
    q(CMD_STBY_Q, 2'h2, 3'h0, 32'h4, 1'b0);
    pulse(19'h10);
    q(CMD_STBY_Q, 2'h2, 3'h0, 32'h5, 1'b0);
    q(CMD_STBY_RUN, 2'h2, 3'h0, 32'h0, 1'b0);
    q(CMD_STBY_Q, 2'h2, 3'h0, 32'h1, 1'b0);
    // second reset after the runs have stopped: every state must fall back to idle
    @(posedge mclk) rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    integDelayUsed <= 1'b0;
    q(CMD_SCOPE_Q, 2'h0, 3'h0, 32'h0, 1'b0);
    q(CMD_STBY_Q, 2'h1, 3'h0, 32'h0, 1'b0);
    q(CMD_ACCUM_RUN, 2'h0, 3'h1, 32'h0, 1'b0);
    q(CMD_ACCUM_Q, 2'h0, 3'h0, 32'h3, 1'b0);
    q(CMD_SCOPE_SET, 2'h0, 3'h1, 32'h0, 1'b0);
    q(CMD_SCOPE_SET, 2'h0, 3'h0, 32'h0, 1'b0);
    q(CMD_SCOPE_Q, 2'h0, 3'h0, 32'h0, 1'b0);
    q(CMD_STBY_RUN, 2'h1, 3'h2, 32'h0, 1'b1);
    q(CMD_STBY_RUN, 2'h1, 3'h1, 32'h0, 1'b0);
    q(CMD_STBY_RUN, 2'h1, 3'h0, 32'h0, 1'b0);
    q(CMD_STBY_Q, 2'h1, 3'h0, 32'h0, 1'b0);
    q(CMD_STBY_Q, 2'h3, 3'h0, 32'h0, 1'b1);
    q(msc_cmd_code_t'(4'ha), 2'h0, 3'h0, 32'h0, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
